// file: design/flash_pkg.sv
/*
 * Shared constants and types for the serial user flash block: array
 * geometry, sector split, timing of the divided oscillator output, pin
 * indices of the synchroniser bank, carrier structs and sequencer states.
 * Assumes a single 25 MHz clock domain and a SystemVerilog-2012 toolchain.
 */
package flash_pkg;

	// Array geometry
	localparam int unsigned ADDR_W        = 9;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned WORDS         = 512;
	localparam int unsigned SECTOR_WORDS  = 256;
	localparam logic [8:0]  ADDR_LAST     = 9'h1FF;
	localparam logic [8:0]  SECTOR0_LAST  = 9'h0FF;
	localparam logic [8:0]  SECTOR1_FIRST = 9'h100;
	localparam int unsigned SECTOR_BIT    = 8;
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;

	// Clock and divided oscillator output
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned CLK_KHZ         = 1000000 / CLK_PERIOD_NS;
	localparam int unsigned OSC_DIV_RATIO   = 4;
	localparam int unsigned OSC_OUT_MIN_KHZ = 4800;
	localparam int unsigned OSC_OUT_MAX_KHZ = 8400;
	localparam int unsigned OSC_OUT_KHZ     = CLK_KHZ / OSC_DIV_RATIO;

	// Global clock lines
	localparam int unsigned GCLK_LINES = 4;

	// Bit positions in the synchroniser bank
	localparam int unsigned PIN_ACLK  = 0;
	localparam int unsigned PIN_ASEL  = 1;
	localparam int unsigned PIN_ADIN  = 2;
	localparam int unsigned PIN_DCLK  = 3;
	localparam int unsigned PIN_DSEL  = 4;
	localparam int unsigned PIN_DIN   = 5;
	localparam int unsigned PIN_PROG  = 6;
	localparam int unsigned PIN_ERASE = 7;
	localparam int unsigned PIN_COUNT = 8;

	// Buffer depth in words
	localparam int unsigned BUF_DEPTH = 2;

	// Source of a serial clock: fabric pin or one global line
	typedef struct packed {
		logic       use_global;
		logic [1:0] line;
	} clk_route_t;

	// Test-port access request
	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} test_req_t;

	// Test-port answer
	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} test_rsp_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PROG,
		ST_ERASE,
		ST_RELEASE
	} op_state_t;

endpackage

// file: design/user_flash_serial_block.sv
/*
 * Serial user flash block: 512 x 16 array in two sectors, serial address
 * and data shift registers, auto-increment stream reads through a
 * two-word buffer, self-timed program and erase with busy, a divided
 * oscillator output and a word-wide test-port path.
 * Assumes serial pins and requests are asynchronous to mclk and are
 * synchronised here; test-port and oscillator enable come from mclk logic.
 */
// Function
// - 512 words addressed by 9 bits
// - Low half sector zero, high half one
// - Words are 16 bits wide
// - Erase clears exactly one sector
// - Request runs self-timed program or erase
// - Operations timed by internal oscillator
// - Oscillator divided by four driven out
// - Single and stream reads supported
// - Select low on address clock increments
// - Nine-bit address, sixteen-bit data shifters
// - Test port also reads and programs
// - Serial clocks from global lines or fabric
`timescale 1ns/1ps
`default_nettype none
module user_flash_serial_block
	import flash_pkg::*;
#(
	parameter int unsigned PROG_CYCLES  = 64,
	parameter int unsigned ERASE_CYCLES = 512
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// Serial address
	input  wire logic              address_shift_clock,
	input  wire logic              address_shift_select,
	input  wire logic              address_serial_in,
	// Serial data
	input  wire logic              data_shift_clock,
	input  wire logic              data_shift_select,
	input  wire logic              data_serial_in,
	output var  logic              data_serial_out,
	// Clock routing
	input  wire logic [3:0]        global_clock_pins,
	input  wire clk_route_t        aclk_route,
	input  wire clk_route_t        dclk_route,
	// Program and erase
	input  wire logic              program_request,
	input  wire logic              erase_request,
	output var  logic              busy,
	// Oscillator
	input  wire logic              osc_out_enable,
	output var  logic              divided_oscillator_out,
	// Test port
	input  wire test_req_t         test_req,
	output var  test_rsp_t         test_rsp
);

	// Parameter checks
	if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_chk_prog
		$error("PROG_CYCLES out of range");
	end
	if (ERASE_CYCLES <= SECTOR_WORDS || ERASE_CYCLES > 65535) begin : g_chk_er
		$error("ERASE_CYCLES must exceed one sector and fit 16 bits");
	end
	if (OSC_OUT_KHZ < OSC_OUT_MIN_KHZ || OSC_OUT_KHZ > OSC_OUT_MAX_KHZ)
	begin : g_chk_osc
		$error("divided oscillator outside its band");
	end

	logic [PIN_COUNT-1:0] raw_pins;             // Routed asynchronous pins
	logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q;     // Three-stage synchroniser
	logic [PIN_COUNT-1:0] f_q, f_d;             // Filtered levels
	logic                 aclk_rise, dclk_rise; // Serial clock edges
	logic [DATA_W-1:0]    mem_q [WORDS];        // Flash array
	logic                 mem_we;               // Array write strobe
	logic [ADDR_W-1:0]    mem_wa;               // Array write address
	logic [DATA_W-1:0]    mem_wd;               // Array write data
	logic [ADDR_W-1:0]    addr_q, addr_d;       // Address shifter
	logic                 fetch_q, fetch_d;     // Word fetch pending
	logic [DATA_W-1:0]    buf_q [BUF_DEPTH];    // Read buffer words
	logic [DATA_W-1:0]    buf_d [BUF_DEPTH];
	logic                 wp_q, wp_d, rp_q, rp_d; // Buffer pointers
	logic [1:0]           bcnt_q, bcnt_d;       // Buffer fill
	logic                 flush, push, pop;     // Buffer controls
	logic [DATA_W-1:0]    sh_q, sh_d;           // Data shifter
	op_state_t            st_q, st_d;           // Sequencer state
	logic [15:0]          opc_q, opc_d;         // Oscillator tick count
	logic [ADDR_W-1:0]    opa_q, opa_d;         // Operation address
	logic [DATA_W-1:0]    opw_q, opw_d;         // Word to program
	logic                 busy_d;
	test_rsp_t            rsp_d;
	logic [1:0]           osc_q, osc_d;         // Divide-by-four counter
	logic                 oscout_d;

	// Serial clock routing ahead of the synchroniser
	// global or fabric
	always_comb begin
		raw_pins = '0;
		raw_pins[PIN_ACLK] = aclk_route.use_global ?
			global_clock_pins[aclk_route.line] : address_shift_clock;
		raw_pins[PIN_DCLK] = dclk_route.use_global ?
			global_clock_pins[dclk_route.line] : data_shift_clock;
		raw_pins[PIN_ASEL]  = address_shift_select;
		raw_pins[PIN_ADIN]  = address_serial_in;
		raw_pins[PIN_DSEL]  = data_shift_select;
		raw_pins[PIN_DIN]   = data_serial_in;
		raw_pins[PIN_PROG]  = program_request;
		raw_pins[PIN_ERASE] = erase_request;
	end

	// A level changes only once stages two and three agree
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
		assign f_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : f_q[i];
	end

	// Synchroniser registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			f_q  <= '0;
		end else begin
			s1_q <= raw_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
		end
	end

	assign aclk_rise = f_d[PIN_ACLK] & ~f_q[PIN_ACLK];
	assign dclk_rise = f_d[PIN_DCLK] & ~f_q[PIN_DCLK];

	// Address shifter, fetch request and buffer next state
	always_comb begin
		addr_d = addr_q;
		fetch_d = fetch_q;
		flush = 1'b0;
		buf_d = buf_q;
		wp_d = wp_q;
		rp_d = rp_q;
		bcnt_d = bcnt_q;
		// Fetch waits while the buffer is full
		push = fetch_q && (bcnt_q < 2'(BUF_DEPTH));
		pop = dclk_rise && !f_q[PIN_DSEL] && (bcnt_q != 2'h0);
		if (push) begin
			fetch_d = 1'b0;
		end
		if (aclk_rise) begin
			fetch_d = 1'b1;
			if (f_q[PIN_ASEL]) begin
				addr_d = {addr_q[ADDR_W-2:0], f_q[PIN_ADIN]};
				flush = 1'b1;
			end else begin
				addr_d = addr_q + 9'h001;
			end
		end
		if (flush) begin
			// New address: stale words are dropped
			wp_d = 1'b0;
			rp_d = 1'b0;
			bcnt_d = 2'h0;
		end else begin
			if (push) begin
				buf_d[wp_q] = mem_q[addr_q];
				wp_d = ~wp_q;
			end
			if (pop) begin
				rp_d = ~rp_q;
			end
			bcnt_d = bcnt_q + 2'(push) - 2'(pop);
		end
	end

	// Address and buffer registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			addr_q <= '0;
			fetch_q <= 1'b0;
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			bcnt_q <= 2'h0;
		end else begin
			addr_q <= addr_d;
			fetch_q <= fetch_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			bcnt_q <= bcnt_d;
		end
		buf_q <= buf_d;
	end

	// Data shifter: select high shifts, low loads buffer head
	always_comb begin
		sh_d = sh_q;
		if (dclk_rise && f_q[PIN_DSEL]) begin
			sh_d = {sh_q[DATA_W-2:0], f_q[PIN_DIN]};
		end else if (pop) begin
			sh_d = buf_q[rp_q];
		end
	end

	// Data shifter register
	always_ff @(posedge mclk) begin
		if (reset) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	// Sequencer next state and array write port
	always_comb begin
		st_d = st_q;
		opc_d = opc_q;
		opa_d = opa_q;
		opw_d = opw_q;
		busy_d = busy;
		rsp_d = '0;
		mem_we = 1'b0;
		mem_wa = opa_q;
		mem_wd = ERASED_WORD;
		unique case (st_q)
			ST_IDLE: begin
				opc_d = '0;
				if (f_q[PIN_PROG]) begin
					st_d = ST_PROG;
					busy_d = 1'b1;
					opa_d = addr_q;
					opw_d = sh_q;
				end else if (f_q[PIN_ERASE]) begin
					st_d = ST_ERASE;
					busy_d = 1'b1;
					opa_d = {addr_q[SECTOR_BIT], 8'h00};
				end else if (test_req.valid) begin
					rsp_d.valid = 1'b1;
					rsp_d.data = mem_q[test_req.addr];
					mem_we = test_req.write;
					mem_wa = test_req.addr;
					mem_wd = mem_q[test_req.addr] & test_req.data;
				end
			end
			ST_PROG: begin
				opc_d = opc_q + 16'h0001;
				if (opc_q == 16'h0000) begin
					mem_we = 1'b1;
					mem_wd = mem_q[opa_q] & opw_q;
				end
				if (opc_q == 16'(PROG_CYCLES - 1)) begin
					st_d = ST_RELEASE;
					busy_d = 1'b0;
				end
			end
			ST_ERASE: begin
				opc_d = opc_q + 16'h0001;
				if (opc_q < 16'(SECTOR_WORDS)) begin
					mem_we = 1'b1;
					mem_wa = {opa_q[SECTOR_BIT], opc_q[7:0]};
				end
				if (opc_q == 16'(ERASE_CYCLES - 1)) begin
					st_d = ST_RELEASE;
					busy_d = 1'b0;
				end
			end
			ST_RELEASE: begin
				if (!f_q[PIN_PROG] && !f_q[PIN_ERASE]) begin
					st_d = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= ST_IDLE;
			opc_q <= '0;
			opa_q <= '0;
			opw_q <= '0;
			busy <= 1'b0;
			test_rsp <= '0;
		end else begin
			st_q <= st_d;
			opc_q <= opc_d;
			opa_q <= opa_d;
			opw_q <= opw_d;
			busy <= busy_d;
			test_rsp <= rsp_d;
		end
	end

	// Array storage: non-volatile, never reset
	// sixteen-bit words
	always_ff @(posedge mclk) begin
		if (mem_we) begin
			mem_q[mem_wa] <= mem_wd;
		end
	end

	// Oscillator divide-by-four output
	always_comb begin
		osc_d = osc_q + 2'h1;
		oscout_d = osc_out_enable & osc_q[1];
	end

	// Oscillator registers and serial data output
	always_ff @(posedge mclk) begin
		if (reset) begin
			osc_q <= 2'h0;
			divided_oscillator_out <= 1'b0;
			data_serial_out <= 1'b0;
		end else begin
			osc_q <= osc_d;
			divided_oscillator_out <= oscout_d;
			data_serial_out <= sh_d[DATA_W-1];
		end
	end

	// Checks
	sequence prog_seen;
		st_q == ST_IDLE && f_q[PIN_PROG];
	endsequence
	sequence osc_high;
		osc_out_enable && $rose(divided_oscillator_out) ##1 osc_out_enable;
	endsequence

	addr_incr_a: assert property (@(posedge mclk) disable iff (reset)
		aclk_rise && !f_q[PIN_ASEL] |=> addr_q == $past(addr_q) + 9'h001)
		else $error("address did not increment");
	addr_shift_a: assert property (@(posedge mclk) disable iff (reset)
		aclk_rise && f_q[PIN_ASEL] |=>
		addr_q == {$past(addr_q[7:0]), $past(f_q[PIN_ADIN])})
		else $error("address shift wrong");
	busy_rise_a: assert property (@(posedge mclk) disable iff (reset)
		prog_seen |=> busy && st_q == ST_PROG ##1 busy)
		else $error("busy did not rise after request");
	prog_end_a: assert property (@(posedge mclk) disable iff (reset)
		st_q == ST_PROG && opc_q == 16'(PROG_CYCLES - 1) |=>
		!busy && st_q == ST_RELEASE)
		else $error("program did not finish on time");
	erase_sector_a: assert property (@(posedge mclk) disable iff (reset)
		mem_we && st_q == ST_ERASE |->
		mem_wa[SECTOR_BIT] == opa_q[SECTOR_BIT] && mem_wd == ERASED_WORD)
		else $error("erase left its sector");
	data_shift_a: assert property (@(posedge mclk) disable iff (reset)
		dclk_rise && f_q[PIN_DSEL] |=>
		sh_q == {$past(sh_q[14:0]), $past(f_q[PIN_DIN])})
		else $error("data shift wrong");
	stream_load_a: assert property (@(posedge mclk) disable iff (reset)
		pop && !f_q[PIN_DSEL] |=> sh_q == $past(buf_q[rp_q]) ##1
		data_serial_out == $past(sh_q[15]))
		else $error("buffer head not loaded");
	osc_div_a: assert property (@(posedge mclk) disable iff (reset)
		osc_high |=> $fell(divided_oscillator_out))
		else $error("oscillator output not divided by four");
	test_wait_a: assert property (@(posedge mclk) disable iff (reset)
		test_req.valid && st_q != ST_IDLE |=> !test_rsp.valid)
		else $error("test port served while busy");
	buf_full_a: assert property (@(posedge mclk) disable iff (reset)
		bcnt_q == 2'h2 && !pop |=> bcnt_q == 2'h2 || $past(flush))
		else $error("buffer lost a word");

endmodule
`default_nettype wire

// file: sim/flash_user_logic.sv
/* Model of the fabric logic that drives the flash block's serial pins.
   Assumes mclk at 25 MHz; pins change 1 ns after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module flash_user_logic #(
	parameter int PH = 5
) (
	// Clock and block outputs
	input  wire logic       mclk,
	input  wire logic       busy,
	input  wire logic       dso,
	// Serial pins, index 0 address, 1 data
	output var  logic [1:0] ck,
	output var  logic [1:0] sel,
	output var  logic [1:0] sd,
	// Operation requests
	output var  logic       prog,
	output var  logic       era
);
	int lag = 0; // Extra cycles held after busy falls

	// Clocks idle low, selects high
	initial begin
		{ck, prog, era} = '0;
		sel = 2'b11;
		sd = 2'b01;
	end

	task automatic wt(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One serial clock pulse, levels held PH cycles around each phase
	task automatic pulse(int w, bit s, bit b, output logic so);
		sel[w] = s;
		sd[w] = b;
		wt(PH);
		ck[w] = 1;
		wt(PH);
		so = dso;
		ck[w] = 0;
		wt(PH);
	endtask

	task automatic set_address(logic [8:0] a);
		logic x;
		for (int i = 8; i >= 0; i--)
			pulse(0, 1, a[i], x);
		sd[0] = ~sd[0];
	endtask

	task automatic step();
		logic x;
		pulse(0, 0, sd[0], x);
	endtask

	// Load buffered word, then shift it out MSB first
	task automatic load_word(output logic [15:0] w);
		pulse(1, 0, sd[1], w[15]);
		for (int i = 14; i >= 0; i--)
			pulse(1, 1, ~sd[1], w[i]);
	endtask

	// Shift a word to program into the data shifter
	task automatic write_word(logic [15:0] v);
		logic x;
		for (int i = 15; i >= 0; i--)
			pulse(1, 1, v[i], x);
	endtask

	task automatic op(bit e, output int n);
		n = 0;
		if (e)
			era = 1;
		else
			prog = 1;
		for (int i = 0; i < 20 && busy !== 1'b1; i++)
			wt(1);
		while (busy === 1'b1 && n < 2000) begin
			n++;
			wt(1);
		end
		wt(lag);
		{prog, era} = 2'b00;
		wt(8);
	endtask
endmodule
`default_nettype wire

// file: sim/user_flash_serial_block_tb.sv
/* Self-checking bench for the serial user flash block.
   Assumes the flash package and the fabric-side partner model. */
`timescale 1ns/1ps
`default_nettype none
module user_flash_serial_block_tb;
	import flash_pkg::*;
	localparam int PC = 4;   // Short program time
	localparam int EC = 260; // Short erase time
	logic        mclk = 0;
	logic        reset = 1;
	logic        oe = 0;   // Divided clock enable
	logic        glob = 0; // Serial clocks via global lines 2 and 3
	logic [1:0]  ck, sel, sd;
	logic        prog, era, busy, dso, osc;
	test_req_t   req = '0;
	test_rsp_t   rsp;
	int          failures = 0;
	int          checks = 0;

	always #20 mclk = ~mclk;

	flash_user_logic #(.PH(5)) partner (
		.mclk(mclk), .busy(busy), .dso(dso), .ck(ck), .sel(sel),
		.sd(sd), .prog(prog), .era(era)
	);

	user_flash_serial_block #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) DUT (
		.mclk(mclk), .reset(reset),
		.address_shift_clock(ck[0] & ~glob),
		.address_shift_select(sel[0]), .address_serial_in(sd[0]),
		.data_shift_clock(ck[1] & ~glob), .data_shift_select(sel[1]),
		.data_serial_in(sd[1]), .data_serial_out(dso),
		.global_clock_pins({ck[1] & glob, ck[0] & glob, 2'b00}),
		.aclk_route({glob, 2'd2}), .dclk_route({glob, 2'd3}),
		.program_request(prog), .erase_request(era), .busy(busy),
		.osc_out_enable(oe), .divided_oscillator_out(osc),
		.test_req(req), .test_rsp(rsp)
	);

	task automatic wt(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Test-port access; answer carries the old word
	task automatic tacc(bit w, logic [8:0] a, logic [15:0] d,
			logic [15:0] e);
		req = '{1'b1, w, a, d};
		wt(1);
		req.valid = 1'b0;
		chk("rsp valid", 16'h0001, {15'h0, rsp.valid});
		chk("rsp data", e, rsp.data);
		wt(1);
	endtask

	// Erase the sector holding address a and time busy
	task automatic t_erase(logic [8:0] a);
		int n;
		partner.set_address(a);
		partner.op(1, n);
		chk("erase busy", 16'(EC), 16'(n));
		// A busy that never rose or never fell ends the run
		if (n == 0 || n >= 2000)
			stop_test();
	endtask

	task automatic t_sectors();
		t_erase(9'h1A5);
		glob = 1;
		t_erase(9'h0FF);
		glob = 0;
		tacc(0, 9'h100, 16'h0, 16'hFFFF);
		tacc(1, 9'h1FF, 16'h1234, 16'hFFFF);
		tacc(1, 9'h000, 16'hA5C3, 16'hFFFF);
		t_erase(9'h055);
		tacc(0, 9'h1FF, 16'h0, 16'h1234);
		tacc(0, 9'h000, 16'h0, 16'hFFFF);
	endtask

	task automatic t_program();
		int n;
		glob = 1;
		partner.set_address(9'h1FE);
		partner.write_word(16'hC3A5);
		glob = 0;
		partner.lag = 3;
		// sector one erased before this program
		fork
			partner.op(0, n);
			begin
				// Test access during the operation gets no answer
				wt(6);
				req = '{1'b1, 1'b0, 9'h1FE, 16'h0};
				wt(1);
				chk("rsp busy", 16'h0, {15'h0, rsp.valid});
				req.valid = 1'b0;
			end
		join
		chk("prog busy", 16'(PC), 16'(n));
		if (n == 0 || n >= 2000)
			stop_test();
		tacc(0, 9'h1FE, 16'h0, 16'hC3A5);
	endtask

	task automatic t_stream();
		logic [15:0] w;
		partner.set_address(9'h1FE);
		partner.load_word(w);
		chk("word 1FE", 16'hC3A5, w);
		partner.step();
		partner.load_word(w);
		chk("word 1FF", 16'h1234, w);
		partner.step();
		partner.load_word(w);
		chk("word 000", 16'hFFFF, w);
	endtask

	task automatic t_osc();
		int i;
		oe = 1;
		for (i = 0; i < 12 && osc !== 1'b1; i++)
			wt(1);
		for (i = 0; i < 4 && osc !== 1'b0; i++)
			wt(1);
		// Output stuck high or unknown: count it and end the run
		if (osc !== 1'b0) begin
			failures++;
			stop_test();
		end
		for (i = 0; i < 8; i++) begin
			chk("osc", {15'h0, (i % 4) > 1}, {15'h0, osc});
			wt(1);
		end
		oe = 0;
		wt(3);
		chk("osc off", 16'h0, {15'h0, osc});
	endtask

	// Cut a hang short
	initial begin
		#4000000;
		failures++;
		stop_test();
	end

	initial begin
		wt(12);
		chk("busy rst", 16'h0, {15'h0, busy});
		chk("osc rst", 16'h0, {15'h0, osc});
		reset = 0;
		wt(6);
		t_sectors();
		t_program();
		t_stream();
		t_osc();
		stop_test();
	end
endmodule
`default_nettype wire
